// ==== fiw_params.svh ====
// Constants for the frame injection table walker
`ifndef FIW_PARAMS_SVH
`define FIW_PARAMS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define FIW_ENTRIES      2048
`define FIW_SEQS         16
`define FIW_TIMERS       16

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FIW_OFS_IDX      8'h00
`define FIW_OFS_LINK     8'h04
`define FIW_OFS_WORD0    8'h08
`define FIW_OFS_DTI      8'h0C
`define FIW_OFS_TCFG     8'h10
`define FIW_OFS_TPER     8'h14
`define FIW_OFS_CAL      8'h18
`define FIW_OFS_STAT     8'h1C

// ----------------------------------------------------------------------
// Entry field positions
// ----------------------------------------------------------------------
`define FIW_LINK_MSB     10
`define FIW_KIND_BIT     16
`define FIW_DESC_MSB     19
`define FIW_RCNT_LSB     20
`define FIW_RCNT_MSB     27
`define FIW_RMREQ_BIT    28
`define FIW_RMST_BIT     29
`define FIW_PATH_BIT     30
`define FIW_DLY_MSB      23

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define FIW_CAL_RST      4'h7
`define FIW_LFSR_SEED    16'hACE1
`define FIW_GAP_CYC      24'h00_000E
`define FIW_CLK_NS       4
`define FIW_TTI_TYP_NS   3000000
`define FIW_TTI_TYP_CYC  (`FIW_TTI_TYP_NS / `FIW_CLK_NS)

`endif

// ==== fiw_pkg.sv ====
// Types shared by the frame injection table walker
package fiw_pkg;

    // Table entry kinds
    typedef enum logic {
        FIW_KIND_FRAME = 1'b0,
        FIW_KIND_DELAY = 1'b1
    } fiw_kind_t;

    // Register slave handshake states
    typedef enum logic [1:0] {
        FIW_AV_IDLE = 2'b01,
        FIW_AV_ACK  = 2'b10
    } fiw_av_t;

endpackage

// ==== fiw_buf2.sv ====
// Two-entry valid/ready buffer in the injection path
`timescale 1ns/100ps
module fiw_buf2 #(
    parameter int W = 26
) (
    // Clock, reset and enable
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    // Filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);

    logic         vld_q;
    logic         full_q;
    logic [W-1:0] head_q;
    logic [W-1:0] tail_q;

    // Handshakes on both sides
    wire push = in_valid & in_ready;
    wire pop  = vld_q & out_ready;

    assign in_ready  = ~full_q;
    assign out_valid = vld_q;
    assign out_data  = head_q;

    // Head always holds the oldest word, so output stays a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            vld_q  <= 1'b0;
            full_q <= 1'b0;
        end else if (ce) begin
            vld_q  <= push | (vld_q & ~(pop & ~full_q));
            full_q <= (full_q & ~pop) | (vld_q & push & ~pop);
        end
    end

    // Data moves only on handshakes
    always_ff @(posedge clk) begin
        if (ce) begin
            if (push & (~vld_q | (pop & ~full_q))) head_q <= in_data;
            else if (pop) head_q <= tail_q;
            if (push & vld_q & ~(pop & ~full_q)) tail_q <= in_data;
        end
    end

    no_overflow_a : assert property (@(posedge clk) disable iff (srst)
        ce && full_q && !pop |=> full_q && head_q == $past(head_q))
        else $error("buffer lost a stored word");

endmodule

// ==== fiw_lfsr.sv ====
// Pseudo-random source for timer jitter
`timescale 1ns/100ps
`include "fiw_params.svh"
module fiw_lfsr (
    // Clock, reset and enable
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    // Random byte
    output logic      [7:0] rnd
);

    logic [15:0] lfsr_q;

    // Galois feedback, maximal length, never reaches zero
    wire  [15:0] lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ 16'hB400)
                                    : (lfsr_q >> 1);

    assign rnd = lfsr_q[7:0];

    // Free running while enabled
    always_ff @(posedge clk) begin
        if (srst) begin
            lfsr_q <= `FIW_LFSR_SEED;
        end else if (ce) begin
            lfsr_q <= lfsr_d;
        end
    end

    lfsr_live_a : assert property (@(posedge clk) disable iff (srst)
        ce |=> lfsr_q != 16'h0000 && lfsr_q != $past(lfsr_q))
        else $error("jitter source stuck");

endmodule

// ==== fiw_walker.sv ====
// Frame injection table walker with delay and timer triggered injection
`timescale 1ns/100ps
`include "fiw_params.svh"
module fiw_walker #(
    parameter logic [23:0] TTI_PERIOD_RST = 24'(`FIW_TTI_TYP_CYC)
) (
    // Clock, reset and enable
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // Avalon-MM register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Injection stream toward the queue system
    output logic             inj_valid,
    input  wire logic        inj_ready,
    output logic      [19:0] inj_descriptor,
    output logic             inj_ingress,
    output logic             inj_timer,
    output logic      [3:0]  inj_source
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [23:0] sat_add(input logic [23:0] a,
                                            input logic [23:0] b);
        logic [24:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[24] ? 24'hFF_FFFF : s[23:0];
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]      lk_mem [`FIW_ENTRIES];
    logic [31:0]      w0_mem [`FIW_ENTRIES];
    logic [10:0]      ptr_q   [`FIW_SEQS];
    logic [10:0]      fptr_q  [`FIW_SEQS];
    logic [7:0]       rep_q   [`FIW_SEQS];
    logic [23:0]      since_q [`FIW_SEQS];
    logic [23:0]      acc_q   [`FIW_SEQS];
    logic [15:0]      dti_active_q;
    logic [3:0]       rr_q;
    logic [10:0]      t_frm_q [`FIW_TIMERS];
    logic [23:0]      t_per_q [`FIW_TIMERS];
    logic [23:0]      t_cnt_q [`FIW_TIMERS];
    logic [15:0]      t_en_q;
    logic [15:0]      t_jit_q;
    logic [2:0]       sub_q [2];
    logic [1:0]       cal_slot_q;
    logic [3:0]       cal_q;
    logic [10:0]      idx_q;
    logic [3:0]       tsel_q;
    logic [15:0]      repeat_count_q;
    fiw_pkg::fiw_av_t av_q;
    logic             wait_q;
    logic [31:0]      rdata_q;
    logic             buf_rdy;
    logic [7:0]       rnd;
    logic [25:0]      buf_out_d;

    // ------------------------------------------------------------------
    // Register slave decode
    // ------------------------------------------------------------------
    wire        bus_req = avs_read | avs_write;
    wire        av_idle = av_q == fiw_pkg::FIW_AV_IDLE;
    wire        sw_wr   = (av_q == fiw_pkg::FIW_AV_ACK) & avs_write;
    wire        hit_idx = avs_address == `FIW_OFS_IDX;
    wire        hit_lnk = avs_address == `FIW_OFS_LINK;
    wire        hit_w0  = avs_address == `FIW_OFS_WORD0;
    wire        hit_dti = avs_address == `FIW_OFS_DTI;
    wire        hit_tcf = avs_address == `FIW_OFS_TCFG;
    wire        hit_tpr = avs_address == `FIW_OFS_TPER;
    wire        hit_cal = avs_address == `FIW_OFS_CAL;
    wire        hit_st  = avs_address == `FIW_OFS_STAT;

    // Read view; also the base that byte enables merge into
    wire [31:0] rd_mux =
        hit_idx ? {21'h00_0000, idx_q} :
        hit_lnk ? lk_mem[idx_q] :
        hit_w0  ? w0_mem[idx_q] :
        hit_dti ? {16'h0000, dti_active_q} :
        hit_tcf ? {15'h0000, t_jit_q[tsel_q], t_en_q[tsel_q],
                   t_frm_q[tsel_q], tsel_q} :
        hit_tpr ? {8'h00, t_per_q[tsel_q]} :
        hit_cal ? {28'h000_0000, cal_q} :
        hit_st  ? {16'h0000, repeat_count_q} : 32'h0000_0000;
    wire [31:0] wv      = be_merge(rd_mux, avs_writedata, avs_byteenable);

    // Sequence start and stop commands, timer configuration write
    wire        sw_dti  = sw_wr & hit_dti;
    wire [3:0]  st_seq  = wv[3:0];
    wire        st_go   = sw_dti & wv[16];
    wire        st_stop = sw_dti & wv[17] & ~wv[16];
    wire        sw_tcf  = sw_wr & hit_tcf;
    wire [3:0]  sw_tsel = wv[3:0];

    // ------------------------------------------------------------------
    // Timer table service
    // ------------------------------------------------------------------
    // Calendar slot picks which half of the timer table is visited
    wire        cal_part = cal_q[cal_slot_q];
    wire [3:0]  ti       = {cal_part, sub_q[cal_part]};
    wire [31:0] tw0      = w0_mem[t_frm_q[ti]];
    wire        t_fire   = t_en_q[ti] & (t_cnt_q[ti] == 24'h00_0000);
    wire        t_want   = t_fire & ~tw0[`FIW_RMREQ_BIT];
    wire        t_go     = t_want & buf_rdy;
    wire        t_skip   = t_fire & tw0[`FIW_RMREQ_BIT];
    wire [23:0] t_jit    = t_jit_q[ti] ? {16'h0000, rnd}
                                       : 24'h00_0000;
    wire [23:0] t_rld    = sat_add(t_per_q[ti], t_jit);

    // ------------------------------------------------------------------
    // Delay-triggered walker, one sequence per cycle
    // ------------------------------------------------------------------
    wire [3:0]  ws      = rr_q;
    wire [10:0] wp      = ptr_q[ws];
    wire [31:0] wlk     = lk_mem[wp];
    wire [31:0] ww0     = w0_mem[wp];
    wire        w_act   = dti_active_q[ws];
    wire        w_dkind = wlk[`FIW_KIND_BIT] ==
                          fiw_pkg::FIW_KIND_DELAY;
    wire [10:0] w_link  = wlk[`FIW_LINK_MSB:0];
    wire [7:0]  w_rc    = ww0[`FIW_RCNT_MSB:`FIW_RCNT_LSB];
    wire [7:0]  w_rep   = rep_q[ws];
    wire [7:0]  w_first = (w_rc == 8'h00) ? 8'h01 : w_rc;
    wire [7:0]  w_left  = ((w_rep == 8'h00) ? w_first : w_rep) - 8'h01;
    // Next frame waits for the delays and the back-to-back floor
    wire [23:0] w_need  = (acc_q[ws] > `FIW_GAP_CYC) ? acc_q[ws]
                                                     : `FIW_GAP_CYC;
    wire        w_due   = since_q[ws] >= w_need;
    wire        w_frm   = w_act & ~w_dkind;
    wire        w_skip  = w_frm & ww0[`FIW_RMREQ_BIT];
    // Timer traffic wins the shared buffer slot
    wire        w_inj   = w_frm & ~ww0[`FIW_RMREQ_BIT] & w_due
                        & buf_rdy & ~t_want;
    wire        w_dly   = w_act & w_dkind;
    wire        w_back  = w_dly & (w_rep != 8'h00);
    wire        w_adv   = w_inj | w_skip | w_dly;
    wire [10:0] w_nptr  = w_back ? fptr_q[ws] : w_link;
    wire        w_end   = w_adv & ~w_back & (w_link == 11'h000);
    wire [15:0] w_clr   = w_end ? (16'h0001 << ws) : 16'h0000;
    wire [15:0] st_set  = st_go ? (16'h0001 << st_seq) : 16'h0000;
    wire [15:0] st_clr  = st_stop ? (16'h0001 << st_seq) : 16'h0000;

    // ------------------------------------------------------------------
    // Injection buffer
    // ------------------------------------------------------------------
    // Only a reference and descriptor leave; the frame stays stored
    wire        buf_in_v = t_go | w_inj;
    wire [25:0] buf_in_d = t_go
        ? {1'b1, ti, tw0[`FIW_PATH_BIT], tw0[`FIW_DESC_MSB:0]}
        : {1'b0, ws, ww0[`FIW_PATH_BIT], ww0[`FIW_DESC_MSB:0]};

    fiw_buf2 #(
        .W         (26)
    ) u_buf (
        .clk       (core_clk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (buf_in_v),
        .in_data   (buf_in_d),
        .in_ready  (buf_rdy),
        .out_valid (inj_valid),
        .out_ready (inj_ready),
        .out_data  (buf_out_d)
    );

    // Path bit steers to loopback (ingress) or rewriter (egress)
    assign inj_descriptor  = buf_out_d[19:0];
    assign inj_ingress     = buf_out_d[20];
    assign inj_source      = buf_out_d[24:21];
    assign inj_timer       = buf_out_d[25];
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    fiw_lfsr u_lfsr (
        .clk  (core_clk),
        .srst (srst),
        .ce   (ce),
        .rnd  (rnd)
    );

    // ------------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then a single acknowledge cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            av_q    <= fiw_pkg::FIW_AV_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            case (av_q)
                fiw_pkg::FIW_AV_IDLE: begin
                    if (bus_req) begin
                        av_q    <= fiw_pkg::FIW_AV_ACK;
                        wait_q  <= 1'b0;
                        rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                fiw_pkg::FIW_AV_ACK: begin
                    av_q   <= fiw_pkg::FIW_AV_IDLE;
                    wait_q <= 1'b1;
                end
                default: begin
                    av_q   <= fiw_pkg::FIW_AV_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // Control registers and activity; a start beats an end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            idx_q        <= 11'h000;
            cal_q        <= `FIW_CAL_RST;
            repeat_count_q    <= 16'h0000;
            dti_active_q <= 16'h0000;
            rr_q         <= 4'h0;
        end else if (ce) begin
            if (sw_wr & hit_idx) idx_q <= wv[10:0];
            if (sw_wr & hit_cal) cal_q <= wv[3:0];
            if (buf_in_v) repeat_count_q <= repeat_count_q + 16'h0001;
            dti_active_q <= (dti_active_q & ~w_clr & ~st_clr) | st_set;
            rr_q         <= rr_q + 4'h1;
        end
    end

    // Tables; hardware status sets land after software writes
    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (sw_wr & hit_lnk) lk_mem[idx_q] <= wv;
            if (sw_wr & hit_w0) w0_mem[idx_q] <= wv;
            if (w_skip) w0_mem[wp][`FIW_RMST_BIT] <= 1'b1;
            if (t_skip) w0_mem[t_frm_q[ti]][`FIW_RMST_BIT] <= 1'b1;
        end
    end

    // Per-sequence walk state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < `FIW_SEQS; i++) begin
                ptr_q[i]   <= 11'h000;
                fptr_q[i]  <= 11'h000;
                rep_q[i]   <= 8'h00;
                since_q[i] <= 24'h00_0000;
                acc_q[i]   <= 24'h00_0000;
            end
        end else if (ce) begin
            for (int i = 0; i < `FIW_SEQS; i++) begin
                since_q[i] <= sat_add(since_q[i], 24'h00_0001);
            end
            if (w_inj) begin
                since_q[ws] <= 24'h00_0000;
                acc_q[ws]   <= 24'h00_0000;
                fptr_q[ws]  <= wp;
            end
            if (w_dly) acc_q[ws] <= sat_add(acc_q[ws],
                                            ww0[`FIW_DLY_MSB:0]);
            if (w_adv) begin
                ptr_q[ws] <= w_nptr;
                rep_q[ws] <= w_inj ? w_left : (w_skip ? 8'h00 : w_rep);
            end
            if (st_go) begin
                ptr_q[st_seq]   <= wv[14:4];
                rep_q[st_seq]   <= 8'h00;
                acc_q[st_seq]   <= 24'h00_0000;
                since_q[st_seq] <= 24'hFF_FFFF;
            end
        end
    end

    // Timer table and calendar position
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cal_slot_q <= 2'h0;
            sub_q[0]   <= 3'h0;
            sub_q[1]   <= 3'h0;
            tsel_q     <= 4'h0;
            t_en_q     <= 16'h0000;
            t_jit_q    <= 16'h0000;
            for (int i = 0; i < `FIW_TIMERS; i++) begin
                t_frm_q[i] <= 11'h000;
                t_per_q[i] <= TTI_PERIOD_RST;
                t_cnt_q[i] <= 24'h00_0000;
            end
        end else if (ce) begin
            cal_slot_q      <= cal_slot_q + 2'h1;
            sub_q[cal_part] <= sub_q[cal_part] + 3'h1;
            if (t_go | t_skip) t_cnt_q[ti] <= t_rld;
            else if (t_en_q[ti] & ~t_fire)
                t_cnt_q[ti] <= t_cnt_q[ti] - 24'h00_0001;
            if (sw_tcf) begin
                tsel_q           <= sw_tsel;
                t_frm_q[sw_tsel] <= wv[14:4];
                t_en_q[sw_tsel]  <= wv[15];
                t_jit_q[sw_tsel] <= wv[16];
                t_cnt_q[sw_tsel] <= t_per_q[sw_tsel];
            end
            if (sw_wr & hit_tpr) t_per_q[tsel_q] <= wv[23:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0]  h_ws_q;
    logic [3:0]  h_ti_q;
    logic [3:0]  h_seq_q;
    logic [10:0] h_ptr_q;
    logic [10:0] h_fptr_q;
    logic [23:0] h_dly_q;
    logic [23:0] h_per_q;
    logic [10:0] h_first_q;

    wire st_same = sw_dti & (st_seq == ws);

    // Snapshot of the step just taken
    always_ff @(posedge core_clk) begin
        if (ce) begin
            h_ws_q    <= ws;
            h_ti_q    <= ti;
            h_seq_q   <= st_seq;
            h_ptr_q   <= wp;
            h_fptr_q  <= fptr_q[ws];
            h_dly_q   <= ww0[`FIW_DLY_MSB:0];
            h_per_q   <= t_per_q[ti];
            h_first_q <= wv[14:4];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    start_load_a : assert property (
        ce && st_go |=> dti_active_q[h_seq_q] &&
            ptr_q[h_seq_q] == h_first_q)
        else $error("sequence start not loaded");
    end_chain_a : assert property (
        ce && w_end && !st_same |=> !dti_active_q[h_ws_q])
        else $error("zero link did not end sequence");
    inj_spacing_a : assert property (
        ce && w_inj |-> since_q[ws] >= `FIW_GAP_CYC &&
            since_q[ws] >= acc_q[ws])
        else $error("frame injected before spacing expired");
    delay_acc_a : assert property (
        ce && w_dly && !st_same |=> acc_q[h_ws_q] >= h_dly_q)
        else $error("delay entry not accumulated");
    repeat_back_a : assert property (
        ce && w_back && !st_same |=> ptr_q[h_ws_q] == h_fptr_q)
        else $error("repeat did not return to frame");
    removal_set_a : assert property (
        ce && w_skip |=> w0_mem[h_ptr_q][`FIW_RMST_BIT])
        else $error("removal status not set");
    tti_reload_a : assert property (
        ce && t_go && !t_jit_q[ti] && !sw_tcf |=> t_cnt_q[h_ti_q] == h_per_q)
        else $error("timer not reloaded with period");
    tti_jitter_a : assert property (
        ce && t_go && t_jit_q[ti] && !sw_tcf |=>
            t_cnt_q[h_ti_q] - h_per_q <= 24'h00_00FF)
        else $error("jitter out of range");
    tti_count_a : assert property (
        ce && t_go |=> repeat_count_q == $past(repeat_count_q) + 16'h0001)
        else $error("timer injection not counted");
    bus_answer_a : assert property (
        ce && bus_req && av_idle |=> !avs_waitrequest)
        else $error("bus request not answered");

    inj_pair_c   : cover property (w_inj ##[1:64] w_inj);
    tti_inject_c : cover property (t_go);
    removal_c    : cover property (w_skip);
    contend_c    : cover property (t_want && w_frm && w_due && buf_rdy);

endmodule

// ==== fiw_sink.sv ====
// Injection sink model for the table walker bench
`timescale 1ns/100ps
module fiw_sink (
    // Clock and control
    input  wire logic        core_clk,
    input  wire logic        hold,
    // Injection stream
    input  wire logic        inj_valid,
    output logic             inj_ready,
    input  wire logic [19:0] inj_descriptor,
    input  wire logic        inj_ingress,
    input  wire logic        inj_timer,
    input  wire logic [3:0]  inj_source,
    // Record of accepted words
    output int               count,
    output logic      [25:0] last,
    output int               gap
);
    int t_q;
    int tl_q;
    initial begin
        inj_ready = 1'b0;
        count = 0;
        gap = 0;
        last = '0;
        t_q = 0;
        tl_q = 0;
    end
    // Ready drops while hold is up; frames are never deleted here
    always @(posedge core_clk) begin
        t_q <= t_q + 1;
        inj_ready <= !hold;
        if (inj_valid && inj_ready) begin
            count <= count + 1;
            last <= {inj_ingress, inj_timer, inj_source, inj_descriptor};
            gap <= t_q - tl_q; // Start to start in cycles
            tl_q <= t_q;
        end
    end
endmodule

// ==== frame_injection_table_walker_tb_top.sv ====
// Testbench for the frame injection table walker
`timescale 1ns/100ps
module frame_injection_table_walker_tb_top;
    logic core_clk = 0, srst = 1, hold = 0, ce = 1;
    logic [7:0] avs_address = '0;
    logic avs_read = 0, avs_write = 0, avs_waitrequest, inj_valid;
    logic [31:0] avs_writedata = '0, avs_readdata, rdat;
    logic inj_ready, inj_ingress, inj_timer;
    logic [19:0] inj_descriptor;
    logic [3:0] inj_source;
    logic [25:0] last;
    int count, gap, fail_count = 0, total_checks = 0, n, c0;
    always #2 core_clk = ~core_clk;
    fiw_walker #(.TTI_PERIOD_RST(24'd20)) u_dut (.core_clk(core_clk),
        .srst(srst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .inj_valid(inj_valid), .inj_ready(inj_ready),
        .inj_descriptor(inj_descriptor), .inj_ingress(inj_ingress),
        .inj_timer(inj_timer), .inj_source(inj_source));
    fiw_sink u_sink (.core_clk(core_clk), .hold(hold),
        .inj_valid(inj_valid), .inj_ready(inj_ready),
        .inj_descriptor(inj_descriptor), .inj_ingress(inj_ingress),
        .inj_timer(inj_timer), .inj_source(inj_source),
        .count(count), .last(last), .gap(gap));
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One Avalon access held until waitrequest is seen low
    // An edge passes first, so back-to-back calls never clash
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        if (w) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        chk(rdat, e);
    endtask
    // Bounded wait for a number of accepted words
    task wait_cnt(input int c);
        n = 0;
        while (count < c && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task results;
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk(32'(avs_waitrequest), 32'h0000_0001);
        rdc(8'h18, 32'h0000_0007);
        rdc(8'h3C, 32'h0000_0000);
        // Frame at 1 repeated twice, then 40-cycle delay at 2, link 0
        acc(1, 8'h00, 32'h0000_0001);
        acc(1, 8'h04, 32'h0000_0002);
        acc(1, 8'h08, 32'h0021_2345);
        rdc(8'h08, 32'h0021_2345);
        acc(1, 8'h00, 32'h0000_0002);
        acc(1, 8'h04, 32'h0001_0000);
        acc(1, 8'h08, 32'h0000_0028);
        rdc(8'h04, 32'h0001_0000);
        acc(1, 8'h0C, 32'h0001_0013);
        rdc(8'h0C, 32'h0000_0008);
        wait_cnt(2);
        chk(32'(count), 32'h0000_0002);
        chk(32'(last), 32'h0031_2345);
        chk(32'(gap >= 40), 32'h0000_0001);
        repeat (200) @(posedge core_clk);
        chk(32'(count), 32'h0000_0002);
        rdc(8'h0C, 32'h0000_0000);
        rdc(8'h1C, 32'h0000_0002);
        // Timer 5 on frame 1 while the sink stalls
        hold <= 1'b1;
        acc(1, 8'h10, 32'h0000_8015);
        rdc(8'h10, 32'h0000_8015);
        // Low clock enable must hold the timer back
        ce <= 1'b0;
        repeat (800) @(posedge core_clk);
        chk(32'(inj_valid), 32'h0000_0000);
        ce <= 1'b1;
        repeat (2500) @(posedge core_clk);
        chk(32'(inj_valid), 32'h0000_0001);
        hold <= 1'b0;
        wait_cnt(5);
        chk(32'(count >= 5), 32'h0000_0001);
        chk(32'(last), 32'h0151_2345);
        // Timer off; removed frame at 3, then ingress frame at 4
        acc(1, 8'h10, 32'h0000_0015);
        repeat (50) @(posedge core_clk);
        c0 = count;
        acc(1, 8'h00, 32'h0000_0003);
        acc(1, 8'h04, 32'h0000_0004);
        acc(1, 8'h08, 32'h1000_0111);
        acc(1, 8'h00, 32'h0000_0004);
        acc(1, 8'h04, 32'h0000_0000);
        acc(1, 8'h08, 32'h4000_0222);
        acc(1, 8'h0C, 32'h0001_0032);
        wait_cnt(c0 + 1);
        repeat (100) @(posedge core_clk);
        chk(32'(count), 32'(c0 + 1));
        chk(32'(last), 32'h0220_0222);
        rdc(8'h0C, 32'h0000_0000);
        acc(1, 8'h00, 32'h0000_0003);
        rdc(8'h08, 32'h3000_0111);
        // Timer 9 with jitter on the ingress frame
        acc(1, 8'h10, 32'h0001_8049);
        wait_cnt(c0 + 2);
        chk(32'(last), 32'h0390_0222);
        results();
    end
endmodule
